// ===== gpw_ports.sv
`timescale 1ns/10ps
`default_nettype none
`include "gpw_defs.svh"
module gpw_ports #(
  parameter logic [7:0] PD_MASK = `GPW_MASK_PD
) (
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic rst,
  // Data memory access port.
  input wire logic [`GPW_ADDR_W-1:0] mem_addr,
  input wire logic mem_wr,
  input wire logic mem_rd,
  input wire logic [7:0] mem_wdata,
  output logic [7:0] mem_rdata,
  // Sleep control.
  input wire logic sleep,
  output logic wake_req,
  // Pins, four ports of eight.
  input wire logic [31:0] pin_in,
  output logic [31:0] pin_out,
  output logic [31:0] pin_oe,
  output logic [31:0] pin_pullup
);
  gpw_pkg::gpw_port_cfg_t cfg_r [4];
  logic [7:0] wake_en_r;
  logic [7:0] pa_prev_r;
  logic [7:0] rdata_r;
  logic wake_r;
  logic [31:0] out_r, oe_r, pu_r;
  gpw_pkg::gpw_state_t st_r, st_nxt;

  wire [1:0] sel_port = mem_addr[3:2];
  wire [1:0] sel_reg = mem_addr[1:0];
  wire [7:0] dir_mask [4];
  wire [7:0] pu_mask [4];
  assign dir_mask[0] = `GPW_MASK_FULL;
  assign dir_mask[1] = `GPW_MASK_FULL;
  assign dir_mask[2] = `GPW_MASK_FULL;
  assign dir_mask[3] = PD_MASK;
  assign pu_mask[0] = `GPW_MASK_A_PU;
  assign pu_mask[1] = `GPW_MASK_FULL;
  assign pu_mask[2] = `GPW_MASK_FULL;
  assign pu_mask[3] = PD_MASK;

  // Output pins show the latch, inputs show the live pin, per bit.
  wire [7:0] port_view [4];
  genvar g;
  generate
    for (g = 0; g < 4; g++)
    begin : g_port
      assign port_view[g] = (cfg_r[g].dat & ~cfg_r[g].dir) | (pin_in[g*8 +: 8] & cfg_r[g].dir);
    end
  endgenerate

  wire wake_sel = (mem_addr == `GPW_OFS_A_WAKE);
  wire [7:0] rd_mux =
    wake_sel ? wake_en_r :
    (sel_reg == 2'h0) ? (port_view[sel_port] & dir_mask[sel_port]) :
    (sel_reg == 2'h1) ? (cfg_r[sel_port].dir & dir_mask[sel_port]) :
    (sel_reg == 2'h2) ? (cfg_r[sel_port].pu & pu_mask[sel_port]) : 8'h00;

  // Falling edges on wake-enabled port A pins.
  wire [7:0] pa_fall = pa_prev_r & ~pin_in[7:0] & wake_en_r;
  wire any_fall = |pa_fall;

  always_comb
  begin
    st_nxt = st_r;
    case (st_r)
      gpw_pkg::GPW_AWAKE: if (sleep) st_nxt = gpw_pkg::GPW_ASLEEP;
      gpw_pkg::GPW_ASLEEP:
        if (!sleep) st_nxt = gpw_pkg::GPW_AWAKE;
        else if (any_fall) st_nxt = gpw_pkg::GPW_WAKING;
      gpw_pkg::GPW_WAKING: if (!sleep) st_nxt = gpw_pkg::GPW_AWAKE;
      default: st_nxt = gpw_pkg::GPW_AWAKE;
    endcase
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      for (int i = 0; i < 4; i++)
      begin
        cfg_r[i].dat <= `GPW_RST_DATA;
        cfg_r[i].dir <= `GPW_RST_DIR;
        cfg_r[i].pu <= `GPW_RST_PU;
      end
      wake_en_r <= `GPW_RST_WAKE;
    end
    else if (mem_wr)
    begin
      if (wake_sel)
        wake_en_r <= mem_wdata;
      else if (sel_reg == 2'h0)
        cfg_r[sel_port].dat <= mem_wdata & dir_mask[sel_port];
      else if (sel_reg == 2'h1)
        cfg_r[sel_port].dir <= (mem_wdata & dir_mask[sel_port]) | ~dir_mask[sel_port];
      else if (sel_reg == 2'h2)
        cfg_r[sel_port].pu <= mem_wdata & pu_mask[sel_port];
    end
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      st_r <= gpw_pkg::GPW_AWAKE;
      pa_prev_r <= 8'hFF;
      wake_r <= 1'b0;
      rdata_r <= 8'h00;
    end
    else
    begin
      st_r <= st_nxt;
      pa_prev_r <= pin_in[7:0];
      wake_r <= (st_nxt == gpw_pkg::GPW_WAKING);
      if (mem_rd)
        rdata_r <= rd_mux;
    end
  end

  // Pin drivers: output when direction 0, pull-high only on inputs.
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      out_r <= 32'hFFFFFFFF;
      oe_r <= 32'h00000000;
      pu_r <= 32'h00000000;
    end
    else
    begin
      for (int i = 0; i < 4; i++)
      begin
        out_r[i*8 +: 8] <= cfg_r[i].dat;
        oe_r[i*8 +: 8] <= ~cfg_r[i].dir & dir_mask[i];
        pu_r[i*8 +: 8] <= cfg_r[i].pu & cfg_r[i].dir & pu_mask[i];
      end
    end
  end

  assign mem_rdata = rdata_r;
  assign wake_req = wake_r;
  assign pin_out = out_r;
  assign pin_oe = oe_r;
  assign pin_pullup = pu_r;

  property p_pu_pin7;
    @(posedge sys_clk) disable iff (rst) !pin_pullup[7];
  endproperty
  a_pu_pin7: assert property (p_pu_pin7) else $error("port A pin 7 pull-high on");

  property p_wake_rise;
    @(posedge sys_clk) disable iff (rst)
      (st_r == gpw_pkg::GPW_ASLEEP && sleep && any_fall) |=> wake_req;
  endproperty
  a_wake_rise: assert property (p_wake_rise) else $error("wake request missed");

  property p_wake_hold;
    @(posedge sys_clk) disable iff (rst) (wake_req && sleep) |=> wake_req;
  endproperty
  a_wake_hold: assert property (p_wake_hold) else $error("wake request dropped in sleep");

  property p_wake_gate;
    @(posedge sys_clk) disable iff (rst) $rose(wake_req) |-> $past(sleep);
  endproperty
  a_wake_gate: assert property (p_wake_gate) else $error("wake request while awake");

  property p_oe_dir;
    @(posedge sys_clk) disable iff (rst) ##1 (pin_oe[7:0] == ~$past(cfg_r[0].dir));
  endproperty
  a_oe_dir: assert property (p_oe_dir) else $error("output enable mismatch");

  property p_dat_hold;
    @(posedge sys_clk) disable iff (rst) !(mem_wr && mem_addr == `GPW_OFS_PA) |=> $stable(cfg_r[0].dat);
  endproperty
  a_dat_hold: assert property (p_dat_hold) else $error("data latch changed");

  property p_pd_rd;
    @(posedge sys_clk) disable iff (rst)
      (mem_rd && mem_addr == `GPW_OFS_D_DIR) |=> (mem_rdata[7:2] == 6'h00);
  endproperty
  a_pd_rd: assert property (p_pd_rd) else $error("unimplemented bits nonzero");

  property p_rd_out;
    @(posedge sys_clk) disable iff (rst)
      (mem_rd && mem_addr == `GPW_OFS_PA && cfg_r[0].dir == 8'h00) |=> (mem_rdata == $past(cfg_r[0].dat));
  endproperty
  a_rd_out: assert property (p_rd_out) else $error("output read not latch");

  // Pull-high and drive never meet on one pin.
  property p_pu_input;
    @(posedge sys_clk) disable iff (rst)
      (pin_pullup & pin_oe) == 32'h00000000;
  endproperty
  a_pu_input: assert property (p_pu_input) else $error("pull-high on a driven pin");

  property p_pa7_pu_reg;
    @(posedge sys_clk) disable iff (rst)
      !cfg_r[0].pu[7];
  endproperty
  a_pa7_pu_reg: assert property (p_pa7_pu_reg) else $error("port A pin 7 pull-high bit set");

  // Register writes land on the next edge.
  property p_dat_write;
    @(posedge sys_clk) disable iff (rst)
      (mem_wr && mem_addr == `GPW_OFS_PA) |=> (cfg_r[0].dat == $past(mem_wdata));
  endproperty
  a_dat_write: assert property (p_dat_write) else $error("data latch not written");

  property p_dir_write;
    @(posedge sys_clk) disable iff (rst)
      (mem_wr && mem_addr == `GPW_OFS_A_DIR) |=> (cfg_r[0].dir == $past(mem_wdata));
  endproperty
  a_dir_write: assert property (p_dir_write) else $error("direction not written");

  property p_pu_write;
    @(posedge sys_clk) disable iff (rst)
      (mem_wr && mem_addr == `GPW_OFS_A_PU) |=> (cfg_r[0].pu == ($past(mem_wdata) & `GPW_MASK_A_PU));
  endproperty
  a_pu_write: assert property (p_pu_write) else $error("pull-high not written");

  property p_wake_write;
    @(posedge sys_clk) disable iff (rst)
      (mem_wr && wake_sel) |=> (wake_en_r == $past(mem_wdata));
  endproperty
  a_wake_write: assert property (p_wake_write) else $error("wake enable not written");

  // Reads of inputs show the pin, unmapped offsets show zero.
  property p_rd_in;
    @(posedge sys_clk) disable iff (rst)
      (mem_rd && mem_addr == `GPW_OFS_PA && cfg_r[0].dir == 8'hFF)
      |=> (mem_rdata == $past(pin_in[7:0]));
  endproperty
  a_rd_in: assert property (p_rd_in) else $error("input read not live pin");

  property p_rd_unmapped;
    @(posedge sys_clk) disable iff (rst)
      (mem_rd && mem_addr[1:0] == 2'h3 && !wake_sel)
      |=> (mem_rdata == 8'h00);
  endproperty
  a_rd_unmapped: assert property (p_rd_unmapped) else $error("unmapped read nonzero");

  property p_rdata_hold;
    @(posedge sys_clk) disable iff (rst)
      !mem_rd |=> $stable(mem_rdata);
  endproperty
  a_rdata_hold: assert property (p_rdata_hold) else $error("read data changed without read");

  // Port D keeps its missing pins as inputs without pull-high.
  property p_pd_hidden;
    @(posedge sys_clk) disable iff (rst)
      cfg_r[3].dir[7:2] == 6'h3F;
  endproperty
  a_pd_hidden: assert property (p_pd_hidden) else $error("port D missing pins not inputs");

  property p_pd_pins;
    @(posedge sys_clk) disable iff (rst)
      (pin_oe[31:26] == 6'h00) && (pin_pullup[31:26] == 6'h00);
  endproperty
  a_pd_pins: assert property (p_pd_pins) else $error("port D missing pins active");

  property p_out_follow;
    @(posedge sys_clk) disable iff (rst)
      ##1 (pin_out[7:0] == $past(cfg_r[0].dat));
  endproperty
  a_out_follow: assert property (p_out_follow) else $error("output pins not latch");

  property p_pu_follow;
    @(posedge sys_clk) disable iff (rst)
      ##1 (pin_pullup[7:0] == $past(cfg_r[0].pu & cfg_r[0].dir));
  endproperty
  a_pu_follow: assert property (p_pu_follow) else $error("pull-high pins mismatch");

  // The wake-up request lives only inside Sleep.
  property p_wake_quiet;
    @(posedge sys_clk) disable iff (rst)
      !sleep |=> !wake_req;
  endproperty
  a_wake_quiet: assert property (p_wake_quiet) else $error("wake request after sleep ended");

  property p_wake_disabled;
    @(posedge sys_clk) disable iff (rst)
      (st_r == gpw_pkg::GPW_ASLEEP && !any_fall) |=> !wake_req;
  endproperty
  a_wake_disabled: assert property (p_wake_disabled) else $error("wake without enabled fall");

  sequence s_fall_asleep;
    (st_r == gpw_pkg::GPW_ASLEEP) && sleep && any_fall;
  endsequence

  sequence s_held_to_wake;
    wake_req ##1 (wake_req || !$past(sleep));
  endsequence

  property p_wake_seq;
    @(posedge sys_clk) disable iff (rst)
      s_fall_asleep |=> s_held_to_wake;
  endproperty
  a_wake_seq: assert property (p_wake_seq) else $error("wake request not held");
endmodule // gpw_ports
`default_nettype wire

// ===== gpw_defs.svh
`ifndef GPW_DEFS_SVH
`define GPW_DEFS_SVH
`define GPW_ADDR_W 4
`define GPW_OFS_PA 4'h0
`define GPW_OFS_A_DIR 4'h1
`define GPW_OFS_A_PU 4'h2
`define GPW_OFS_A_WAKE 4'h3
`define GPW_OFS_PB 4'h4
`define GPW_OFS_B_DIR 4'h5
`define GPW_OFS_B_PU 4'h6
`define GPW_OFS_PC 4'h8
`define GPW_OFS_C_DIR 4'h9
`define GPW_OFS_C_PU 4'hA
`define GPW_OFS_PD 4'hC
`define GPW_OFS_D_DIR 4'hD
`define GPW_OFS_D_PU 4'hE
`define GPW_RST_DATA 8'hFF
`define GPW_RST_DIR 8'hFF
`define GPW_RST_PU 8'h00
`define GPW_RST_WAKE 8'h00
`define GPW_MASK_FULL 8'hFF
`define GPW_MASK_A_PU 8'h7F
`define GPW_MASK_PD 8'h03
`endif

// ===== gpw_pkg.sv
package gpw_pkg;
  typedef struct packed {
    logic [7:0] dat;
    logic [7:0] dir;
    logic [7:0] pu;
  } gpw_port_cfg_t;
  typedef enum logic [1:0] {
    GPW_AWAKE = 2'b00,
    GPW_ASLEEP = 2'b01,
    GPW_WAKING = 2'b11
  } gpw_state_t;
endpackage

// ===== gpw_board.sv
`timescale 1ns/10ps
`default_nettype none
module gpw_board (
  // Clock.
  input wire logic sys_clk,
  // Device pins.
  input wire logic [31:0] pin_out,
  input wire logic [31:0] pin_oe,
  input wire logic [31:0] pin_pullup,
  // Board drivers.
  input wire logic [31:0] ext_en,
  input wire logic [31:0] ext_val,
  output logic [31:0] pin_in
);
  logic [31:0] float_r = 32'h5555_5555;
  // A pin that nobody drives and nothing pulls up wanders every cycle.
  always @(posedge sys_clk) float_r <= ~float_r;
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_en & ext_val)
    | (~pin_oe & ~ext_en & (pin_pullup | float_r));
endmodule // gpw_board
`default_nettype wire

// ===== testbench.sv
`timescale 1ns/10ps
`default_nettype none
`include "gpw_defs.svh"
module testbench;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic [`GPW_ADDR_W-1:0] mem_addr = 4'h0;
  logic mem_wr = 1'b0;
  logic mem_rd = 1'b0;
  logic [7:0] mem_wdata = 8'h00;
  logic [7:0] mem_rdata;
  logic sleep = 1'b0;
  logic wake_req;
  logic [31:0] pin_in, pin_out, pin_oe, pin_pullup;
  logic [31:0] ext_en = 32'hFFFF_FFFF;
  logic [31:0] ext_val = 32'h0296_C35A;
  int err_total = 0;
  int num_checks = 0;
  initial forever #10 sys_clk = ~sys_clk;
  gpw_ports dut_u (.sys_clk(sys_clk), .rst(rst), .mem_addr(mem_addr), .mem_wr(mem_wr), .mem_rd(mem_rd),
    .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .sleep(sleep), .wake_req(wake_req), .pin_in(pin_in),
    .pin_out(pin_out), .pin_oe(pin_oe), .pin_pullup(pin_pullup));
  gpw_board board_u (.sys_clk(sys_clk), .pin_out(pin_out), .pin_oe(pin_oe), .pin_pullup(pin_pullup),
    .ext_en(ext_en), .ext_val(ext_val), .pin_in(pin_in));
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    mem_addr = a;
    mem_wdata = d;
    mem_wr = 1'b1;
    @(negedge sys_clk);
    mem_wr = 1'b0;
    @(negedge sys_clk);
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] exp);
    mem_addr = a;
    mem_rd = 1'b1;
    @(negedge sys_clk);
    mem_rd = 1'b0;
    @(negedge sys_clk);
    chk({24'h0, mem_rdata}, {24'h0, exp});
  endtask
  task automatic wait_wake(input logic v);
    int n = 0;
    while (wake_req !== v && n < 20)
    begin
      @(negedge sys_clk);
      n++;
    end
    chk({31'h0, wake_req}, {31'h0, v});
  endtask
  initial
  begin
    repeat (3) @(negedge sys_clk);
    rst = 1'b0;
    chk(pin_oe, 32'h0);
    chk(pin_out, 32'hFFFF_FFFF);
    rd(`GPW_OFS_A_DIR, 8'hFF);
    rd(`GPW_OFS_D_DIR, 8'h03);
    rd(`GPW_OFS_A_WAKE, 8'h00);
    rd(`GPW_OFS_B_PU, 8'h00);
    rd(`GPW_OFS_PB, 8'hC3);
    rd(`GPW_OFS_PD, 8'h02);
    wr(4'h7, 8'hFF);
    rd(4'h7, 8'h00);
    wr(`GPW_OFS_A_PU, 8'hFF);
    rd(`GPW_OFS_A_PU, 8'h7F);
    wr(`GPW_OFS_D_PU, 8'hFF);
    rd(`GPW_OFS_D_PU, 8'h03);
    ext_en = 32'hFFFF_FF80;
    chk(pin_pullup, 32'h0300_007F);
    rd(`GPW_OFS_PA, 8'h7F);
    wr(`GPW_OFS_A_PU, 8'h00);
    repeat (2) @(negedge sys_clk);
    chk(pin_pullup, 32'h0300_0000);
    ext_en = 32'hFFFF_FFFF;
    wr(`GPW_OFS_PA, 8'hA5);
    wr(`GPW_OFS_A_DIR, 8'h0F);
    repeat (2) @(negedge sys_clk);
    chk(pin_oe, 32'h0000_00F0);
    chk(pin_out, 32'hFFFF_FFA5);
    rd(`GPW_OFS_PA, 8'hAA);
    ext_val = 32'h0296_C353;
    rd(`GPW_OFS_PA, 8'hA3);
    wr(`GPW_OFS_A_DIR, 8'hFF);
    wr(`GPW_OFS_A_DIR, 8'h00);
    for (int p = 1; p < 4; p++)
      wr(4'(p * 4 + 1), 8'h00);
    repeat (2) @(negedge sys_clk);
    chk(pin_out, 32'hFFFF_FFA5);
    chk(pin_oe, 32'h03FF_FFFF);
    rd(`GPW_OFS_PA, 8'hA5);
    ext_val = 32'h0296_C3FF;
    wr(`GPW_OFS_A_DIR, 8'hFF);
    wr(`GPW_OFS_A_WAKE, 8'h01);
    ext_val[0] = 1'b0;
    repeat (3) @(negedge sys_clk);
    chk({31'h0, wake_req}, 32'h0);
    ext_val[0] = 1'b1;
    sleep = 1'b1;
    repeat (3) @(negedge sys_clk);
    ext_val[1] = 1'b0;
    repeat (3) @(negedge sys_clk);
    chk({31'h0, wake_req}, 32'h0);
    ext_val[0] = 1'b0;
    wait_wake(1'b1);
    sleep = 1'b0;
    wait_wake(1'b0);
    tally_and_finish();
  end
endmodule // testbench
`default_nettype wire
